// ==== src/flash_program_erase_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_map.svh"
module flash_program_erase_sequencer
    import flash_seq_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_req,
    input wire op_e i_op,
    input wire logic [19:0] i_addr,
    input wire logic [15:0] i_data,
    input wire logic i_supply_ok,
    input wire logic [15:0] i_dq_in,
    output logic o_busy,
    output logic o_done,
    output logic o_error,
    output logic [7:0] o_status,
    output logic o_supply_err,
    output logic [19:0] o_flash_addr,
    output logic [15:0] o_dq_out,
    output logic o_dq_oe,
    output logic o_chip_en_b,
    output logic o_write_en_b,
    output logic o_out_en_b,
    output logic o_reset_powerdown_pin_b,
    output logic o_write_protect_b
);
    typedef struct packed {
        seq_e state;
        op_e op;
        logic [19:0] addr;
        logic [15:0] data;
        logic [7:0] cmd1;
        logic two_writes;
        logic poll;
        logic [31:0] polls;
        logic [7:0] status;
        logic busy;
        logic done;
        logic error;
        logic supply_err;
        logic [19:0] fa;
        logic [15:0] dq;
        logic oe;
        logic ce_b;
        logic we_b;
        logic re_b;
        logic rp_b;
        logic wp_b;
    } seq_s;
    seq_s s_reg;
    seq_s s_next;
    logic t_load;
    logic [7:0] t_count;
    logic t_exp;
    // one timer paces write pulses, gaps and read access
    bus_timer u_timer (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_load(t_load),
        .i_count(t_count),
        .o_expire(t_exp)
    );
    // sequencer: choose command bytes, drive strobes, poll the ready bit
    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        t_load = 1'b0;
        t_count = 8'(`WRITE_CYCLES);
        case (s_reg.state)
            st_idle: begin
                if (i_req) begin
                    s_next.op = i_op;
                    s_next.addr = i_addr;
                    s_next.data = i_data;
                    s_next.two_writes = 1'b0;
                    s_next.poll = 1'b0;
                    s_next.busy = 1'b1;
                    s_next.error = 1'b0;
                    s_next.polls = '0;
                    case (i_op)
                        op_erase: begin
                            // device pre-programs and erases the block
                            s_next.cmd1 = `CMD_ERASE_SETUP;
                            s_next.data = {8'h00, `CMD_ERASE_CONFIRM};
                            s_next.two_writes = 1'b1;
                            s_next.poll = 1'b1;
                        end
                        op_program: begin
                            s_next.cmd1 = `CMD_PROG_SETUP;
                            s_next.two_writes = 1'b1;
                            s_next.poll = 1'b1;
                        end
                        op_otp_program: begin
                            s_next.cmd1 = `CMD_OTP_SETUP;
                            s_next.two_writes = 1'b1;
                            s_next.poll = 1'b1;
                        end
                        op_clear_status: begin
                            s_next.cmd1 = `CMD_CLEAR_STATUS;
                        end
                        op_suspend: begin
                            s_next.cmd1 = `CMD_SUSPEND;
                        end
                        op_resume: begin
                            // resume re-enters busy, so wait for ready again
                            s_next.cmd1 = `CMD_RESUME;
                            s_next.poll = 1'b1;
                        end
                        op_read_array: begin
                            s_next.cmd1 = `CMD_READ_ARRAY;
                        end
                        default: begin
                            s_next.cmd1 = `CMD_READ_STATUS;
                            s_next.poll = 1'b1;
                        end
                    endcase
                    // host may not start program or erase on a bad supply
                    if (!i_supply_ok && (i_op == op_erase ||
                        i_op == op_program || i_op == op_otp_program)) begin
                        s_next.busy = 1'b0;
                        s_next.done = 1'b1;
                        s_next.error = 1'b1;
                        s_next.supply_err = 1'b1;
                    end else begin
                        s_next.state = st_write1;
                        s_next.fa = i_addr;
                        s_next.dq = {8'h00, s_next.cmd1};
                        s_next.oe = 1'b1;
                        s_next.ce_b = 1'b0;
                        s_next.we_b = 1'b0;
                        t_load = 1'b1;
                    end
                end
            end
            st_write1: begin
                if (t_exp) begin
                    s_next.we_b = 1'b1;
                    s_next.ce_b = 1'b1;
                    t_load = 1'b1;
                    s_next.state = st_gap;
                end
            end
            st_gap: begin
                if (t_exp) begin
                    if (s_reg.two_writes) begin
                        // second write carries block or word address
                        s_next.two_writes = 1'b0;
                        s_next.fa = s_reg.addr;
                        s_next.dq = s_reg.data;
                        s_next.ce_b = 1'b0;
                        s_next.we_b = 1'b0;
                        t_load = 1'b1;
                        s_next.state = st_write2;
                    end else if (s_reg.poll) begin
                        // any read now returns status, no 70h needed
                        s_next.oe = 1'b0;
                        s_next.ce_b = 1'b0;
                        s_next.re_b = 1'b0;
                        t_count = 8'(`READ_CYCLES);
                        t_load = 1'b1;
                        s_next.state = st_poll_read;
                    end else begin
                        s_next.oe = 1'b0;
                        s_next.state = st_done;
                    end
                end
            end
            st_write2: begin
                if (t_exp) begin
                    s_next.we_b = 1'b1;
                    s_next.ce_b = 1'b1;
                    t_load = 1'b1;
                    s_next.state = st_gap;
                end
            end
            st_poll_read: begin
                if (t_exp) begin
                    s_next.ce_b = 1'b1;
                    s_next.re_b = 1'b1;
                    s_next.status = i_dq_in[7:0];
                    s_next.status[`ST_RESERVED] = 1'b0;
                    s_next.polls = s_reg.polls + 32'h1;
                    // ready bit or runaway poll ends the wait; suspend bits are not checked
                    if (i_dq_in[`ST_READY] ||
                        s_reg.polls == `POLL_LIMIT) begin
                        s_next.state = st_done;
                    end else begin
                        t_load = 1'b1;
                        s_next.state = st_gap;
                    end
                end
            end
            st_done: begin
                s_next.busy = 1'b0;
                s_next.done = 1'b1;
                // b3 is sticky on the device until a clear-status
                if (s_reg.op == op_clear_status) begin
                    s_next.supply_err = 1'b0;
                end else if (s_reg.status[`ST_SUPPLY_BAD]) begin
                    s_next.supply_err = 1'b1;
                end
                if (s_reg.poll) begin
                    s_next.error = s_reg.status[`ST_ERASE_FAIL] |
                        s_reg.status[`ST_PROG_FAIL] |
                        s_reg.status[`ST_SUPPLY_BAD] |
                        s_reg.status[`ST_PROTECTED] |
                        ~s_reg.status[`ST_READY];
                end
                s_next.state = st_idle;
            end
            default: begin
                s_next.state = st_idle;
            end
        endcase
        // keep pins deasserted in every state: invalid sequences never leak
        s_next.rp_b = 1'b1;
        s_next.wp_b = 1'b1;
    end
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s_reg <= '0;
            s_reg.state <= st_idle;
            s_reg.op <= op_read_array;
            s_reg.ce_b <= 1'b1;
            s_reg.we_b <= 1'b1;
            s_reg.re_b <= 1'b1;
            s_reg.status <= 8'h80;
            // pins sit high from reset on, so the device never sees a dip
            s_reg.rp_b <= 1'b1;
            s_reg.wp_b <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end
    assign o_busy = s_reg.busy;
    assign o_done = s_reg.done;
    assign o_error = s_reg.error;
    assign o_status = s_reg.status;
    assign o_supply_err = s_reg.supply_err;
    assign o_flash_addr = s_reg.fa;
    assign o_dq_out = s_reg.dq;
    assign o_dq_oe = s_reg.oe;
    assign o_chip_en_b = s_reg.ce_b;
    assign o_write_en_b = s_reg.we_b;
    assign o_out_en_b = s_reg.re_b;
    assign o_reset_powerdown_pin_b = s_reg.rp_b;
    assign o_write_protect_b = s_reg.wp_b;
endmodule // flash_program_erase_sequencer
`default_nettype wire

// ==== src/flash_seq_map.svh ====
`ifndef FLASH_SEQ_MAP_SVH
`define FLASH_SEQ_MAP_SVH
// command codes written on the data bus
`define CMD_ERASE_SETUP 8'h20
`define CMD_ERASE_CONFIRM 8'hd0
`define CMD_RESUME 8'hd0
`define CMD_PROG_SETUP 8'h40
`define CMD_PROG_SETUP_ALT 8'h10
`define CMD_OTP_SETUP 8'h30
`define CMD_CLEAR_STATUS 8'h50
`define CMD_READ_STATUS 8'h70
`define CMD_SUSPEND 8'hb0
`define CMD_READ_ARRAY 8'hff
// status bit positions
`define ST_READY 7
`define ST_ERASE_SUSP 6
`define ST_ERASE_FAIL 5
`define ST_PROG_FAIL 4
`define ST_SUPPLY_BAD 3
`define ST_PROG_SUSP 2
`define ST_PROTECTED 1
`define ST_RESERVED 0
// bus timing, in ns, and derived cycles at 5 ns
`define CLK_PERIOD_NS 5
`define T_WRITE_PULSE_NS 60
`define T_READ_ACCESS_NS 120
`define WRITE_CYCLES ((`T_WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_CYCLES ((`T_READ_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POLL_LIMIT 32'h00ff_ffff
`endif

// ==== src/flash_seq_pkg.sv ====
package flash_seq_pkg;
    typedef enum logic [2:0] {
        op_erase, op_program, op_otp_program, op_clear_status,
        op_suspend, op_resume, op_read_array, op_read_status
    } op_e;
    typedef enum {
        st_idle, st_write1, st_gap, st_write2, st_poll_read, st_done
    } seq_e;
endpackage

// ==== src/bus_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_map.svh"
// down counter that pulses o_expire after the loaded number of cycles
module bus_timer (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_load,
    input wire logic [7:0] i_count,
    output logic o_expire
);
    typedef struct packed {
        logic [7:0] cnt;
        logic run;
        logic expire;
    } tmr_s;
    tmr_s s_reg;
    tmr_s s_next;
    // load wins over a running count so a new phase restarts cleanly
    always_comb begin
        s_next = s_reg;
        s_next.expire = 1'b0;
        if (i_load) begin
            s_next.cnt = i_count;
            s_next.run = 1'b1;
        end else if (s_reg.run) begin
            if (s_reg.cnt <= 8'h01) begin
                s_next.run = 1'b0;
                s_next.expire = 1'b1;
            end else begin
                s_next.cnt = s_reg.cnt - 8'h01;
            end
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
    assign o_expire = s_reg.expire;
endmodule // bus_timer
`default_nettype wire

// ==== sim/flash_seq_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module flash_seq_checker
    import flash_seq_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_req,
    input wire op_e i_op,
    input wire logic i_supply_ok,
    input wire logic o_busy,
    input wire logic o_done,
    input wire logic o_error,
    input wire logic [7:0] o_status,
    input wire logic o_supply_err,
    input wire logic o_dq_oe,
    input wire logic o_chip_en_b,
    input wire logic o_write_en_b,
    input wire logic o_out_en_b,
    input wire logic o_reset_powerdown_pin_b,
    input wire logic o_write_protect_b
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // a request counts only while idle
    logic take;
    assign take = i_req && !o_busy;
    a_done_pulse: assert property (o_done |=> !o_done)
        else $error("done too long");
    a_idle_at_done: assert property (o_done |-> !o_busy)
        else $error("busy at done");
    a_refuse_supply: assert property (take && !i_supply_ok &&
        i_op inside {op_erase, op_program, op_otp_program}
        |=> o_done && o_error && o_supply_err && o_write_en_b)
        else $error("bad supply not refused");
    a_supply_sticky: assert property (o_supply_err && !o_busy && !take
        |=> o_supply_err) else $error("supply flag lost");
    a_status_rsvd: assert property (o_status[0] == 1'b0)
        else $error("reserved status bit set");
    a_write_drive: assert property (!o_write_en_b
        |-> o_dq_oe && !o_chip_en_b && o_out_en_b) else $error("bad write");
    a_read_release: assert property (!o_out_en_b |-> !o_dq_oe)
        else $error("bus driven in read");
    a_write_len: assert property ($fell(o_write_en_b)
        |-> !o_write_en_b [*8] ##5 !o_write_en_b ##1 o_write_en_b)
        else $error("write pulse length");
    a_pins_held: assert property
        (o_reset_powerdown_pin_b && o_write_protect_b) else $error("pins low");
    // main flows
    c_erase: cover property (take && i_op == op_erase);
    c_error: cover property (o_done && o_error);
    c_clear: cover property ($fell(o_supply_err));
endmodule // flash_seq_checker
bind flash_program_erase_sequencer flash_seq_checker chk (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(i_req), .i_op(i_op),
    .i_supply_ok(i_supply_ok), .o_busy(o_busy), .o_done(o_done),
    .o_error(o_error), .o_status(o_status), .o_supply_err(o_supply_err),
    .o_dq_oe(o_dq_oe), .o_chip_en_b(o_chip_en_b),
    .o_write_en_b(o_write_en_b), .o_out_en_b(o_out_en_b),
    .o_reset_powerdown_pin_b(o_reset_powerdown_pin_b),
    .o_write_protect_b(o_write_protect_b));
`default_nettype wire

// ==== sim/flash_dev_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// behavioural flash: status mode only, array contents not kept
module flash_dev_model (
    input wire logic i_ce_b,
    input wire logic i_we_b,
    input wire logic i_oe_b,
    input wire logic i_rp_b,
    input wire logic i_vpp_ok,
    input wire logic i_fail,
    input wire logic [19:0] i_addr,
    input wire logic [15:0] i_din,
    output logic [15:0] o_dout
);
    logic [7:0] sr = 8'h80;
    logic [7:0] setup = 8'hff;
    logic [7:0] held = 8'h80;
    logic [19:0] ca, block_addr;
    logic [15:0] cd;
    logic cc;
    // busy long enough that the first poll still sees busy
    task automatic run(input int fail_bit);
        sr[7] = 1'b0;
        if (!i_rp_b) sr[1] = 1'b1;
        #200;
        if (!i_vpp_ok || !i_rp_b) sr[3] = 1'b1;
        else if (i_fail) sr[fail_bit] = 1'b1;
        sr[7] = 1'b1;
    endtask
    // capture 1 ns after the write strobe falls, once the bus has settled
    always @(negedge i_we_b) #1 {ca, cd, cc} = {i_addr, i_din, i_ce_b};
    // commands act at write end; writes during a run are lost
    always @(posedge i_we_b) begin
        if (!cc) begin
            if (setup == 8'h20) begin
                setup = 8'hff;
                block_addr = ca;
                if (cd[7:0] != 8'hd0) sr[5:4] = 2'b11;
                else run(5);
            end else if (setup != 8'hff) begin
                setup = 8'hff;
                run(4);
            end else if (cd[7:0] == 8'h50) sr[5:3] = 3'b000;
            else if (cd[7:0] == 8'hd0) {sr[6], sr[2]} = 2'b00;
            else if (cd[7:0] inside {8'h20, 8'h40, 8'h10, 8'h30})
                setup = cd[7:0];
        end
    end
    // status latched as the read opens; released bus shows the inverse
    always @(negedge i_oe_b) held = sr;
    assign o_dout = (!i_ce_b && !i_oe_b) ? {8'h00, held} : ~{8'h00, held};
endmodule // flash_dev_model
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    import flash_seq_pkg::*;
    localparam logic [9:0] ALL = 10'h3ff, SE = 10'h200, ERR = 10'h300;
    logic i_clk = 0, i_rst_b = 0, i_req = 0, i_supply_ok = 1;
    logic vpp = 1, fail = 0, we_q;
    op_e i_op = op_erase;
    logic [19:0] i_addr = 20'h0, r;
    logic [15:0] i_data = 16'h0, i_dq_in, dev_dq, rnd = 16'h9dd8;
    logic o_busy, o_done, o_error, o_supply_err, o_dq_oe, o_chip_en_b;
    logic o_write_en_b, o_out_en_b, o_reset_powerdown_pin_b;
    logic o_write_protect_b;
    logic [7:0] o_status;
    logic [19:0] o_flash_addr;
    logic [15:0] o_dq_out;
    logic [36:0] w;
    logic [36:0] wq[$];
    logic [19:0] rq[$];
    int err_count = 0, n_tests = 0, n_done = 0, cyc = 0;
    logic [7:0] code[8] = '{8'h20, 8'h40, 8'h30, 8'h50,
        8'hb0, 8'hd0, 8'hff, 8'h70};
    initial forever #2.5 i_clk = ~i_clk;
    // data wire: whoever has its enable up
    assign i_dq_in = o_dq_oe ? o_dq_out : dev_dq;
    flash_program_erase_sequencer uut (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(i_req), .i_op(i_op),
        .i_addr(i_addr), .i_data(i_data), .i_supply_ok(i_supply_ok),
        .i_dq_in(i_dq_in), .o_busy(o_busy), .o_done(o_done),
        .o_error(o_error), .o_status(o_status), .o_supply_err(o_supply_err),
        .o_flash_addr(o_flash_addr), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe),
        .o_chip_en_b(o_chip_en_b), .o_write_en_b(o_write_en_b),
        .o_out_en_b(o_out_en_b),
        .o_reset_powerdown_pin_b(o_reset_powerdown_pin_b),
        .o_write_protect_b(o_write_protect_b));
    flash_dev_model dev (
        .i_ce_b(o_chip_en_b), .i_we_b(o_write_en_b), .i_oe_b(o_out_en_b),
        .i_rp_b(o_reset_powerdown_pin_b), .i_vpp_ok(vpp), .i_fail(fail),
        .i_addr(o_flash_addr), .i_din(i_dq_in), .o_dout(dev_dq));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // note the pin writes and the result, then issue one request
    task automatic do_op(input op_e op, input logic [19:0] a,
        input logic ok, input logic [19:0] exp);
        int k;
        k = n_done + 1;
        if (ok || op > op_otp_program)
            wq.push_back({1'b0, 20'h0, 8'h00, code[op]});
        if (ok && op == op_erase)
            wq.push_back({1'b1, a, 16'h00d0});
        else if (ok && op <= op_otp_program)
            wq.push_back({1'b1, a, ~a[15:0]});
        rq.push_back(exp);
        @(negedge i_clk);
        i_req = 1'b1;
        i_op = op;
        i_addr = a;
        i_data = ~a[15:0];
        i_supply_ok = ok;
        @(negedge i_clk);
        i_req = 1'b0;
        wait (n_done == k);
    endtask
    // watcher: settled outputs are judged at the falling edge
    always @(negedge i_clk) begin
        if (o_done === 1'b1) begin
            r = rq.pop_front();
            check(36'({o_supply_err, o_error, o_status} & r[19:10]),
                36'(r[9:0]));
            n_done++;
        end
        if (o_write_en_b === 1'b0 && we_q === 1'b1) begin
            w = (wq.size() > 0) ? wq.pop_front() : '1;
            check({w[36] ? o_flash_addr : 20'h0, o_dq_out}, w[35:0]);
        end
        we_q = o_write_en_b;
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end
    // main sequence; the host clears errors before new work, except the refused erase right after the supply failure
    initial begin
        repeat (12) @(negedge i_clk);
        i_rst_b = 1'b1;
        do_op(op_erase, 20'h1a000, 1'b1, {ALL, 10'h080});
        do_op(op_otp_program, 20'h000ff, 1'b1, {ALL, 10'h080});
        fail = 1'b1;
        do_op(op_program, 20'h02345, 1'b1, {ALL, 10'h190});
        do_op(op_clear_status, 20'h0, 1'b1, {SE, 10'h000});
        do_op(op_erase, 20'h4a000, 1'b1, {ALL, 10'h1a0});
        fail = 1'b0;
        do_op(op_clear_status, 20'h0, 1'b1, {SE, 10'h000});
        do_op(op_read_status, 20'h0, 1'b1, {ALL, 10'h080});
        vpp = 1'b0;
        do_op(op_program, 20'h05555, 1'b1, {ALL, 10'h388});
        vpp = 1'b1;
        do_op(op_erase, 20'h06000, 1'b0, {ERR, 10'h300});
        do_op(op_read_status, 20'h0, 1'b1, {ALL, 10'h388});
        do_op(op_clear_status, 20'h0, 1'b1, {SE, 10'h000});
        do_op(op_read_status, 20'h0, 1'b1, {ALL, 10'h080});
        for (int i = 4; i < 7; i++)
            do_op(op_e'(i), 20'h0, 1'b1, {ALL, 10'h080});
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            do_op(op_e'(i % 3), {rnd[3:0], rnd}, 1'b1, {ALL, 10'h080});
        end
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
